// file: rdc_trigger_config.sv
// Added by the designer: the plain strobed port.
`timescale 1ns/100ps
// Summary of operation
// - cycle-time bit set doubles conversion cycle, measured in low-freq oscillator periods
// - three-bit guard amplifier current trim held in low bits of first register
// - ten-bit trigger divider; 0 and 1 pass all, N passes every Nth
// - same divider value divides oscillator ticks when timer is trigger source
// - trigger source field: off, timer, pin, conversion end async or sync
// - start command begins a measurement whatever trigger source is selected
// - averaging field selects 1, 4, 8 or 16 counted samples
// - two-bit mask enables reference and sensor resistor ports
// - internal temperature sensor included only when its enable bit is set
// - internal reference resistor included only when its enable bit is set
// - two or eight discarded warm-up cycles precede the counted samples
// - two-bit field picks which of four general pins may start measurement
module rdc_trigger_config
  import rdc_trigger_config_pkg::*;
#(
  parameter int PREDIV_WIDTH = 10
) (
  // clock and reset
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst,
  // register port
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rdata,
  // trigger inputs
  input  wire logic       i_olf_tick,
  input  wire logic [3:0] i_gp_pin,
  input  wire logic       i_cdc_done,
  input  wire logic       i_start_cmd,
  // sequence status
  output logic            o_res_busy,
  output logic            o_warmup_phase,
  output logic            o_sample_strobe,
  output logic            o_res_done,
  // port enables
  output logic            o_reference_resistor_port,
  output logic            o_sensor_resistor_port,
  output logic            o_internal_temp_sensor,
  output logic            o_internal_ref_resistor,
  // analog trim and tuning
  output logic      [2:0] o_guard_amp_current_trim,
  output logic      [5:0] o_tune_fields,
  output logic      [5:0] o_tune_count
);

  // ***************************************************************
  // state
  // ***************************************************************
  typedef struct packed {
    logic                    res_cycle_double;
    logic [2:0]              guard_amp_current_trim;
    logic [PREDIV_WIDTH-1:0] res_trigger_divider;
    logic [2:0]              res_trigger_source;
    logic [1:0]              res_average_depth;
    logic [1:0]              port_mask;
    logic                    internal_temp_sensor_enable;
    logic                    internal_ref_resistor_enable;
    logic                    warm_long;
    logic [1:0]              res_start_pin_select;
    logic [5:0]              tune_a;
    logic [5:0]              tune_count;
    logic [7:0]              rdata;
    seq_state_t              state;
    logic                    tick_cnt;
    logic [3:0]              warm_cnt;
    logic [4:0]              samp_cnt;
    logic                    pin_prev;
    logic                    sync_pend;
    logic                    done;
    logic                    strobe;
    logic [3:0]              ports;
  } ctl_state_t;

  ctl_state_t st;
  ctl_state_t next_st;

  // ***************************************************************
  // helpers
  // ***************************************************************
  function automatic logic [4:0] avg_target(input logic [1:0] depth);
    case (depth)
      2'h0:    avg_target = AVG_NONE;
      2'h1:    avg_target = AVG_4;
      2'h2:    avg_target = AVG_8;
      default: avg_target = AVG_16;
    endcase
  endfunction

  function automatic logic [3:0] warm_target(input logic long_sel);
    warm_target = long_sel ? WARM_LONG : WARM_SHORT;
  endfunction

  function automatic logic [7:0] reg_read(input ctl_state_t s, input logic [7:0] a);
    reg_read = 8'h00;
    case (a)
      ADDR_CYCLE_GUARD_TRIM: begin
        reg_read[CYCLE_DOUBLE_BIT] = s.res_cycle_double;
        reg_read[GUARD_TRIM_LSB +: 3] = s.guard_amp_current_trim;
      end
      ADDR_PREDIVIDER_LOW:
        reg_read = s.res_trigger_divider[7:0];
      ADDR_TRIGGER_AVERAGE: begin
        reg_read[TRIG_SRC_LSB +: 3] = s.res_trigger_source;
        reg_read[AVG_DEPTH_LSB +: 2] = s.res_average_depth;
        reg_read[PREDIV_HI_LSB +: 2] = s.res_trigger_divider[9:8];
      end
      ADDR_PORT_WARMUP_PIN: begin
        reg_read[PORT_MASK_LSB +: 2] = s.port_mask;
        reg_read[ITEMP_EN_BIT] = s.internal_temp_sensor_enable;
        reg_read[IREF_EN_BIT] = s.internal_ref_resistor_enable;
        reg_read[WARM_LONG_BIT] = s.warm_long;
        reg_read[PIN_SEL_LSB +: 2] = s.res_start_pin_select;
      end
      ADDR_TUNING_A:
        reg_read[TUNE_A_LSB +: 6] = s.tune_a;
      ADDR_TUNING_B:
        reg_read[TUNE_COUNT_LSB +: 6] = s.tune_count;
      ADDR_SEQ_STATUS: begin
        reg_read[STAT_BUSY_BIT] = (s.state != ST_IDLE);
        reg_read[STAT_WARM_BIT] = (s.state == ST_WARM);
        reg_read[STAT_SAMP_LSB +: 5] = s.samp_cnt;
      end
      default:
        reg_read = 8'h00;
    endcase
  endfunction

  // ***************************************************************
  // trigger path
  // ***************************************************************
  logic pin_level;
  logic pin_rise;
  logic event_raw;
  logic event_div;
  logic olf_div;
  logic auto_start;
  logic start_req;
  logic cycle_end;

  // selected start pin and its rising edge
  assign pin_level = i_gp_pin[st.res_start_pin_select];
  assign pin_rise  = pin_level && !st.pin_prev;

  // codes 2, 4 and 7 act as off
  assign event_raw = ((st.res_trigger_source == TRIG_PIN) && pin_rise)
                   || ((st.res_trigger_source == TRIG_CDC_ASYNC) && i_cdc_done)
                   || ((st.res_trigger_source == TRIG_CDC_SYNC) && i_cdc_done);

  // event pre-divider
  trigger_divider #(
    .WIDTH (PREDIV_WIDTH)
  ) u_event_div (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_pulse   (event_raw),
    .i_ratio   (st.res_trigger_divider),
    .o_pulse   (event_div)
  );

  // same ratio divides the oscillator for the timer source
  trigger_divider #(
    .WIDTH (PREDIV_WIDTH)
  ) u_olf_div (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_pulse   (i_olf_tick && (st.res_trigger_source == TRIG_TIMER)),
    .i_ratio   (st.res_trigger_divider),
    .o_pulse   (olf_div)
  );

  // sync mode waits for the next oscillator tick after the conversion end
  assign auto_start = olf_div
                    || (event_div && (st.res_trigger_source != TRIG_CDC_SYNC))
                    || (st.sync_pend && i_olf_tick);
  assign start_req  = i_start_cmd || auto_start;

  // doubled cycle needs two oscillator periods
  assign cycle_end = i_olf_tick && (!st.res_cycle_double || st.tick_cnt);

  // ***************************************************************
  // next state
  // ***************************************************************
  always_comb begin
    next_st = st;
    next_st.pin_prev = pin_level;
    next_st.done     = 1'b0;
    next_st.strobe   = 1'b0;
    // read data valid only in the cycle after the strobe
    next_st.rdata    = i_rd ? reg_read(st, i_addr) : 8'h00;

    // register writes
    if (i_wr) begin
      case (i_addr)
        ADDR_CYCLE_GUARD_TRIM: begin
          next_st.res_cycle_double = i_wdata[CYCLE_DOUBLE_BIT];
          next_st.guard_amp_current_trim = i_wdata[GUARD_TRIM_LSB +: 3];
        end
        ADDR_PREDIVIDER_LOW:
          next_st.res_trigger_divider[7:0] = i_wdata;
        ADDR_TRIGGER_AVERAGE: begin
          next_st.res_trigger_source = i_wdata[TRIG_SRC_LSB +: 3];
          next_st.res_average_depth = i_wdata[AVG_DEPTH_LSB +: 2];
          next_st.res_trigger_divider[9:8] = i_wdata[PREDIV_HI_LSB +: 2];
        end
        ADDR_PORT_WARMUP_PIN: begin
          next_st.port_mask = i_wdata[PORT_MASK_LSB +: 2];
          next_st.internal_temp_sensor_enable = i_wdata[ITEMP_EN_BIT];
          next_st.internal_ref_resistor_enable = i_wdata[IREF_EN_BIT];
          next_st.warm_long = i_wdata[WARM_LONG_BIT];
          next_st.res_start_pin_select = i_wdata[PIN_SEL_LSB +: 2];
        end
        ADDR_TUNING_A:
          next_st.tune_a = i_wdata[TUNE_A_LSB +: 6];
        ADDR_TUNING_B:
          next_st.tune_count = i_wdata[TUNE_COUNT_LSB +: 6];
        default: begin
        end
      endcase
    end

    // pending sync start, set wins over the tick that consumes it
    if (event_div && (st.res_trigger_source == TRIG_CDC_SYNC)) begin
      next_st.sync_pend = 1'b1;
    end else if (i_olf_tick) begin
      next_st.sync_pend = 1'b0;
    end

    // conversion sequencer; triggers during a run are dropped
    case (st.state)
      ST_IDLE: begin
        if (start_req) begin
          next_st.state     = ST_WARM;
          next_st.tick_cnt  = 1'b0;
          next_st.warm_cnt  = 4'h0;
          next_st.samp_cnt  = 5'h00;
          next_st.sync_pend = 1'b0;
        end
      end
      ST_WARM: begin
        if (i_olf_tick) begin
          next_st.tick_cnt = cycle_end ? 1'b0 : 1'b1;
        end
        if (cycle_end) begin
          // warm-up results are discarded: no strobe
          if (st.warm_cnt == 4'(warm_target(st.warm_long) - 4'h1)) begin
            next_st.state = ST_MEAS;
          end else begin
            next_st.warm_cnt = 4'(st.warm_cnt + 4'h1);
          end
        end
      end
      ST_MEAS: begin
        if (i_olf_tick) begin
          next_st.tick_cnt = cycle_end ? 1'b0 : 1'b1;
        end
        if (cycle_end) begin
          next_st.strobe   = 1'b1;
          next_st.samp_cnt = 5'(st.samp_cnt + 5'h01);
          if (5'(st.samp_cnt + 5'h01) == avg_target(st.res_average_depth)) begin
            next_st.state = ST_IDLE;
            next_st.done  = 1'b1;
          end
        end
      end
      default:
        next_st.state = ST_IDLE;
    endcase

    // port enables follow the run and the enable bits
    if (next_st.state != ST_IDLE) begin
      next_st.ports = {st.internal_ref_resistor_enable,
                       st.internal_temp_sensor_enable,
                       st.port_mask};
    end else begin
      next_st.ports = 4'h0;
    end
  end

  // ***************************************************************
  // registers
  // ***************************************************************
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      st                        <= '0;
      st.guard_amp_current_trim <= RST_GUARD_TRIM;
      st.res_trigger_source     <= RST_TRIG_SRC;
      st.res_trigger_divider    <= RST_PREDIV;
      st.tune_a                 <= RST_TUNE_A;
      st.tune_count             <= RST_TUNE_COUNT;
      st.state                  <= ST_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // outputs
  assign o_rdata                   = st.rdata;
  assign o_res_busy                = (st.state != ST_IDLE);
  assign o_warmup_phase            = (st.state == ST_WARM);
  assign o_sample_strobe           = st.strobe;
  assign o_res_done                = st.done;
  assign o_reference_resistor_port = st.ports[0];
  assign o_sensor_resistor_port    = st.ports[1];
  assign o_internal_temp_sensor    = st.ports[2];
  assign o_internal_ref_resistor   = st.ports[3];
  assign o_guard_amp_current_trim  = st.guard_amp_current_trim;
  assign o_tune_fields             = st.tune_a;
  assign o_tune_count              = st.tune_count;

  // ***************************************************************
  // assertions
  // ***************************************************************
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  cycle_doubling_a: assert property (
    (st.state == ST_MEAS && st.res_cycle_double && !st.tick_cnt && i_olf_tick)
    |=> !o_sample_strobe)
    else $error("doubled cycle ended after one tick");

  trim_write_a: assert property (
    (i_wr && i_addr == ADDR_CYCLE_GUARD_TRIM)
    |=> o_guard_amp_current_trim == $past(i_wdata[2:0]))
    else $error("guard trim not taken from write");

  prediv_pass_a: assert property (
    (event_raw && st.res_trigger_divider <= 10'h001) |-> event_div)
    else $error("divider blocked event at ratio one");

  timer_start_a: assert property (
    (st.state == ST_IDLE && st.res_trigger_source == TRIG_TIMER && i_olf_tick
     && st.res_trigger_divider <= 10'h001) |=> st.state == ST_WARM)
    else $error("timer tick did not start run");

  source_off_a: assert property (
    (st.state == ST_IDLE && st.res_trigger_source == TRIG_OFF && !i_start_cmd
     && !st.sync_pend) |=> st.state == ST_IDLE)
    else $error("run started with source off");

  opcode_start_a: assert property (
    (st.state == ST_IDLE && i_start_cmd) |=> (o_res_busy && o_warmup_phase))
    else $error("start command ignored");

  avg_count_a: assert property (
    o_res_done |-> (st.samp_cnt == avg_target(st.res_average_depth) && !o_res_busy))
    else $error("wrong sample count at done");

  port_gate_a: assert property (
    (o_res_busy && $past(o_res_busy) && !$past(i_wr))
    |-> (o_reference_resistor_port == st.port_mask[0]
         && o_sensor_resistor_port == st.port_mask[1]))
    else $error("resistor port enable mismatch");

  internal_gate_a: assert property (
    !o_res_busy ##1 !o_res_busy
    |-> !o_internal_temp_sensor && !o_internal_ref_resistor)
    else $error("internal path enabled while idle");

  warm_count_a: assert property (
    (st.state == ST_WARM ##1 st.state == ST_MEAS)
    |-> $past(st.warm_cnt) == 4'(warm_target(st.warm_long) - 4'h1))
    else $error("warm-up count wrong");

  pin_start_a: assert property (
    (st.state == ST_IDLE && st.res_trigger_source == TRIG_PIN && pin_rise
     && st.res_trigger_divider <= 10'h001) |=> st.state == ST_WARM)
    else $error("selected pin did not start run");

  full_avg_c: cover property (o_res_done && st.res_average_depth == 2'h3);
  pin_run_c: cover property (st.res_trigger_source == TRIG_PIN && pin_rise ##1 o_res_busy);
  sync_run_c: cover property (st.sync_pend ##[1:100] o_res_busy);
  long_warm_c: cover property (st.warm_long && o_warmup_phase ##[1:200] !o_warmup_phase);

endmodule

// file: rdc_trigger_config_pkg.sv
package rdc_trigger_config_pkg;

  // ***************************************************************
  // register map
  // ***************************************************************
  localparam logic [7:0] ADDR_CYCLE_GUARD_TRIM = 8'h14;
  localparam logic [7:0] ADDR_PREDIVIDER_LOW   = 8'h15;
  localparam logic [7:0] ADDR_TRIGGER_AVERAGE  = 8'h16;
  localparam logic [7:0] ADDR_PORT_WARMUP_PIN  = 8'h17;
  localparam logic [7:0] ADDR_TUNING_A         = 8'h18;
  localparam logic [7:0] ADDR_TUNING_B         = 8'h19;
  localparam logic [7:0] ADDR_SEQ_STATUS       = 8'h3f;

  // ***************************************************************
  // field positions
  // ***************************************************************
  localparam int CYCLE_DOUBLE_BIT = 7;
  localparam int GUARD_TRIM_LSB   = 0;
  localparam int PREDIV_HI_LSB    = 0;
  localparam int AVG_DEPTH_LSB    = 2;
  localparam int TRIG_SRC_LSB     = 4;
  localparam int PIN_SEL_LSB      = 0;
  localparam int WARM_LONG_BIT    = 2;
  localparam int IREF_EN_BIT      = 4;
  localparam int ITEMP_EN_BIT     = 5;
  localparam int PORT_MASK_LSB    = 6;
  localparam int TUNE_A_LSB       = 0;
  localparam int TUNE_COUNT_LSB   = 2;
  localparam int STAT_BUSY_BIT    = 0;
  localparam int STAT_WARM_BIT    = 1;
  localparam int STAT_SAMP_LSB    = 2;

  // ***************************************************************
  // reset values
  // ***************************************************************
  localparam logic [2:0]  RST_GUARD_TRIM = 3'h7;
  localparam logic [2:0]  RST_TRIG_SRC   = 3'h0;
  localparam logic [9:0]  RST_PREDIV     = 10'h000;
  localparam logic [5:0]  RST_TUNE_A     = 6'h33;
  localparam logic [5:0]  RST_TUNE_COUNT = 6'h01;

  // ***************************************************************
  // trigger sources, averaging, warm-up, cycle length
  // ***************************************************************
  localparam logic [2:0] TRIG_OFF       = 3'h0;
  localparam logic [2:0] TRIG_TIMER     = 3'h1;
  localparam logic [2:0] TRIG_PIN       = 3'h3;
  localparam logic [2:0] TRIG_CDC_ASYNC = 3'h5;
  localparam logic [2:0] TRIG_CDC_SYNC  = 3'h6;

  localparam logic [4:0] AVG_NONE = 5'h01;
  localparam logic [4:0] AVG_4    = 5'h04;
  localparam logic [4:0] AVG_8    = 5'h08;
  localparam logic [4:0] AVG_16   = 5'h10;

  localparam logic [3:0] WARM_SHORT = 4'h2;
  localparam logic [3:0] WARM_LONG  = 4'h8;

  // low-freq oscillator periods per conversion cycle: 1 normal, 2 doubled
  localparam logic [1:0] CYCLE_TICKS_SHORT = 2'h1;
  localparam logic [1:0] CYCLE_TICKS_LONG  = 2'h2;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WARM = 2'b01,
    ST_MEAS = 2'b10
  } seq_state_t;

endpackage

// file: trigger_divider.sv
`timescale 1ns/100ps
module trigger_divider
  import rdc_trigger_config_pkg::*;
#(
  parameter int WIDTH = 10
) (
  // clock and reset
  input  wire logic             i_sys_clk,
  input  wire logic             i_rst,
  // event in, ratio, event out
  input  wire logic             i_pulse,
  input  wire logic [WIDTH-1:0] i_ratio,
  output logic                  o_pulse
);

  typedef struct packed {
    logic [WIDTH-1:0] cnt;
  } div_state_t;

  div_state_t st;
  div_state_t next_st;

  // ratio 0 and 1 pass every event; >= tolerates a ratio lowered mid-count
  assign o_pulse = i_pulse && ((i_ratio <= WIDTH'(1))
                   || (st.cnt >= WIDTH'(i_ratio - WIDTH'(1))));

  // event counter
  always_comb begin
    next_st = st;
    if (i_pulse) begin
      next_st.cnt = o_pulse ? '0 : WIDTH'(st.cnt + WIDTH'(1));
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

endmodule

// file: olf_cdc_source.sv
`timescale 1ns/100ps
module olf_cdc_source #(
  parameter int TICK_GAP = 4
) (
  // clock and reset
  input  wire logic i_sys_clk,
  input  wire logic i_rst,
  // controls from the bench
  input  wire logic i_tick_en,
  input  wire logic i_cdc_req,
  // events towards the block
  output logic      o_olf_tick,
  output logic      o_cdc_done
);
  int   gap;
  logic req_q;

  // ***************************************************************
  // oscillator ticks and conversion-end pulses
  // ***************************************************************
  // one tick every TICK_GAP cycles; the oscillator stands still when disabled
  always_ff @(posedge i_sys_clk) begin
    if (i_rst || !i_tick_en) begin
      gap        <= 0;
      o_olf_tick <= 1'b0;
    end else begin
      gap        <= (gap == TICK_GAP - 1) ? 0 : gap + 1;
      o_olf_tick <= (gap == TICK_GAP - 1);
    end
  end

  // one conversion-end pulse per rising request, so a held request fires once
  always_ff @(posedge i_sys_clk) begin
    req_q      <= i_rst ? 1'b0 : i_cdc_req;
    o_cdc_done <= !i_rst && i_cdc_req && !req_q;
  end
endmodule

// file: rdc_trigger_config_bench.sv
`timescale 1ns/100ps
module rdc_trigger_config_bench;
  import rdc_trigger_config_pkg::*;

  // ***************************************************************
  // signals
  // ***************************************************************
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic [7:0] rdata;
  logic       tick;
  logic       cdc_done;
  logic [3:0] gp_pin = 4'h0;
  logic       start_cmd = 1'b0;
  logic       tick_en = 1'b1;
  logic       cdc_req = 1'b0;
  logic       busy;
  logic       warm;
  logic       samp;
  logic       done;
  logic       ref_port;
  logic       sns_port;
  logic       itemp;
  logic       iref;
  logic [2:0] trim;
  logic [5:0] tune_f;
  logic [5:0] tune_c;
  int         err_count = 0;
  int         checks_done = 0;

  always #25 clk = ~clk;

  rdc_trigger_config uut (
    .i_sys_clk(clk), .i_rst(rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .o_rdata(rdata), .i_olf_tick(tick), .i_gp_pin(gp_pin), .i_cdc_done(cdc_done),
    .i_start_cmd(start_cmd), .o_res_busy(busy), .o_warmup_phase(warm),
    .o_sample_strobe(samp), .o_res_done(done), .o_reference_resistor_port(ref_port),
    .o_sensor_resistor_port(sns_port), .o_internal_temp_sensor(itemp),
    .o_internal_ref_resistor(iref), .o_guard_amp_current_trim(trim),
    .o_tune_fields(tune_f), .o_tune_count(tune_c)
  );

  olf_cdc_source src (
    .i_sys_clk(clk), .i_rst(rst), .i_tick_en(tick_en), .i_cdc_req(cdc_req),
    .o_olf_tick(tick), .o_cdc_done(cdc_done)
  );

  // ***************************************************************
  // shared tasks
  // ***************************************************************
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1 check(rdata, exp);
  endtask

  // bounded wait for busy to reach a level
  task automatic wait_busy(input logic want, input int bound);
    int n;
    n = 0;
    while (busy !== want && n < bound) begin
      @(negedge clk);
      n++;
    end
    if (busy !== want) begin
      err_count++;
      $display("[FAIL] %0t busy never reached %b", $time, want);
      test_done();
    end
  endtask

  // conversion-end pulse, then a settle gap of a few cycles
  task automatic cdc_pulse();
    @(posedge clk);
    cdc_req <= 1'b1;
    @(posedge clk);
    cdc_req <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
  endtask

  // start by command, count ticks, warm-up ticks and samples of one run
  task automatic run(input logic [7:0] avg, input logic [7:0] pm, input logic dbl,
                     input int ticks, input int wticks, input int samples);
    int nt;
    int nw;
    int ns;
    int n;
    reg_wr(ADDR_CYCLE_GUARD_TRIM, {dbl, 7'h07});
    reg_wr(ADDR_TRIGGER_AVERAGE, avg);
    reg_wr(ADDR_PORT_WARMUP_PIN, pm);
    @(posedge clk);
    start_cmd <= 1'b1;
    @(posedge clk);
    start_cmd <= 1'b0;
    #1 check({7'h00, busy}, 8'h01);
    check({4'h0, sns_port, ref_port, itemp, iref}, {4'h0, pm[7:4]});
    nt = 0;
    nw = 0;
    ns = 0;
    n  = 0;
    while (done !== 1'b1 && n < 3000) begin
      @(negedge clk);
      n++;
      if (tick === 1'b1 && busy === 1'b1) nt++;
      if (tick === 1'b1 && warm === 1'b1) nw++;
      if (samp === 1'b1) ns++;
    end
    // a run that never finishes ends the test here
    if (done !== 1'b1) begin
      err_count++;
      $display("[FAIL] %0t run never finished", $time);
      test_done();
    end
    check(8'(nt), 8'(ticks));
    check(8'(nw), 8'(wticks));
    check(8'(ns), 8'(samples));
    check({4'h0, sns_port, ref_port, itemp, iref}, 8'h00);
    reg_rd(ADDR_SEQ_STATUS, 8'(samples << 2));
  endtask

  // ***************************************************************
  // main sequence
  // ***************************************************************
  localparam logic [7:0] ADRS [6] = '{8'h14, 8'h15, 8'h16, 8'h17, 8'h18, 8'h19};
  localparam logic [7:0] MSKS [6] = '{8'h87, 8'hff, 8'h7f, 8'hf7, 8'h3f, 8'hfc};

  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    // reset values, then writable bits of each register
    reg_rd(ADDR_CYCLE_GUARD_TRIM, 8'h07);
    check({5'h00, trim}, 8'h07);
    reg_rd(ADDR_TUNING_A, 8'h33);
    reg_rd(ADDR_TUNING_B, 8'h04);
    // read data stand one cycle only, then fall back to zero
    @(posedge clk);
    #1 check(rdata, 8'h00);
    for (int i = 0; i < 6; i++) begin
      reg_wr(ADRS[i], 8'hff);
      reg_rd(ADRS[i], MSKS[i]);
    end
    reg_wr(8'h20, 8'hff);
    reg_rd(8'h20, 8'h00);
    reg_wr(ADDR_PREDIVIDER_LOW, 8'h00);
    // host programs the fixed tuning values
    reg_wr(ADDR_TUNING_A, 8'h33);
    reg_wr(ADDR_TUNING_B, 8'h04);
    #1 check({2'h0, tune_f}, 8'h33);
    check({2'h0, tune_c}, 8'h01);
    // command runs over averaging, warm-up and cycle length
    run(8'h00, 8'h40, 1'b0, 3, 2, 1);
    run(8'h54, 8'h84, 1'b0, 12, 8, 4);
    run(8'h08, 8'h20, 1'b1, 20, 4, 8);
    run(8'h0c, 8'hd0, 1'b0, 18, 2, 16);
    reg_wr(ADDR_PORT_WARMUP_PIN, 8'h00);
    // divided conversion-end triggers: only every third one starts
    reg_wr(ADDR_PREDIVIDER_LOW, 8'h03);
    reg_wr(ADDR_TRIGGER_AVERAGE, 8'h50);
    cdc_pulse();
    cdc_pulse();
    check({7'h00, busy}, 8'h00);
    cdc_pulse();
    check({7'h00, busy}, 8'h01);
    wait_busy(1'b0, 200);
    reg_wr(ADDR_PREDIVIDER_LOW, 8'h00);
    cdc_pulse();
    check({7'h00, busy}, 8'h01);
    wait_busy(1'b0, 200);
    // source off ignores conversion ends
    reg_wr(ADDR_TRIGGER_AVERAGE, 8'h00);
    cdc_pulse();
    check({7'h00, busy}, 8'h00);
    // synchronous mode waits for the next oscillator tick
    reg_wr(ADDR_TRIGGER_AVERAGE, 8'h60);
    tick_en <= 1'b0;
    cdc_pulse();
    check({7'h00, busy}, 8'h00);
    @(posedge clk);
    tick_en <= 1'b1;
    wait_busy(1'b1, 20);
    wait_busy(1'b0, 200);
    // timer source; switched off mid-run so it does not retrigger
    reg_wr(ADDR_TRIGGER_AVERAGE, 8'h10);
    wait_busy(1'b1, 20);
    reg_wr(ADDR_TRIGGER_AVERAGE, 8'h00);
    wait_busy(1'b0, 200);
    // pin source: only the selected pin starts
    reg_wr(ADDR_PORT_WARMUP_PIN, 8'h02);
    reg_wr(ADDR_TRIGGER_AVERAGE, 8'h30);
    @(posedge clk);
    gp_pin <= 4'h2;
    repeat (4) @(posedge clk);
    #1 check({7'h00, busy}, 8'h00);
    @(posedge clk);
    gp_pin <= 4'h6;
    wait_busy(1'b1, 10);
    reg_wr(ADDR_TRIGGER_AVERAGE, 8'h00);
    wait_busy(1'b0, 200);
    test_done();
  end
endmodule
